// ---- rtl/coproc_exception_sequencer.sv ----
// exception sequencer for coprocessor instructions with AXI4-Lite regs
//
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "cx_map.svh"
module coproc_exception_sequencer
    import cx_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // axi4-lite write
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // events from the processor core
    input wire cx_pkg::ev_s ev,
    // interface register actions
    output logic resp_read,
    output logic abort_wr,
    output logic restore_wr,
    output logic dialog_end,
    // exception request
    output logic req_valid,
    input wire logic req_ready,
    output cx_pkg::req_s req,
    output logic [31:0] frame_pc
);
    import cx_pkg::*;

    typedef struct packed {
        state_e st;
        op_e op;
        logic [1:0] tmode;
        logic tpend;
        logic cof;
        logic first;
        logic trc;
        logic irqw;
        logic en;
        logic [7:0] last_vec;
        logic [15:0] count;
        logic [31:0] fpc;
        logic aw_ok, w_ok;
        logic [ADDR_W-1:0] awa;
        logic [31:0] wd;
        logic [3:0] ws;
        logic bv;
        logic [1:0] br;
        logic rv;
        logic [31:0] rd;
        logic [1:0] rr;
    } st_s;

    st_s s;
    st_s next_s;
    prim_s p;
    logic ld;
    req_s ldq;
    logic take_trc;
    logic cof_now;

    // ==========================================================
    // trace decision at instruction end
    function automatic logic trace_take(input logic [1:0] tm,
            input op_e op, input logic cof, input logic flow);
        trace_take = (tm == `CX_TM_EACH) ||
            (tm == `CX_TM_FLOW && ((op == OP_GEN) ? cof : flow));
    endfunction : trace_take

    prim_decode u_dec (
        .word(ev.prim),
        .p(p)
    );

    exc_request u_req (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .ld(ld),
        .d(ldq),
        .valid(req_valid),
        .ready(req_ready),
        .q(req)
    );

    // status primitive with direction set marks a flow change
    assign cof_now = s.cof || (ev.prim_vld && p.is_stat && p.dr &&
        s.tmode == `CX_TM_FLOW);
    assign take_trc = trace_take(s.tmode, s.op, cof_now, ev.flow_chg);

    // ==========================================================
    // sequencer and register bus, all held while ce is low
    always_comb begin
        next_s = s;
        resp_read = 1'h0;
        abort_wr = 1'h0;
        restore_wr = 1'h0;
        dialog_end = 1'h0;
        ld = 1'h0;
        ldq = '0;
        awready = 1'h0;
        wready = 1'h0;
        arready = 1'h0;
        if (ce) begin
            // write address and data may come in either order
            awready = !s.aw_ok && !s.bv;
            wready = !s.w_ok && !s.bv;
            arready = !s.rv;
            if (awvalid && awready) begin
                next_s.aw_ok = 1'h1;
                next_s.awa = awaddr;
            end
            if (wvalid && wready) begin
                next_s.w_ok = 1'h1;
                next_s.wd = wdata;
                next_s.ws = wstrb;
            end
            if (s.aw_ok && s.w_ok) begin
                next_s.aw_ok = 1'h0;
                next_s.w_ok = 1'h0;
                next_s.bv = 1'h1;
                next_s.br = 2'h0;
                if (s.awa == `CX_REG_CTRL) begin
                    if (s.ws[0]) begin
                        next_s.en = s.wd[0];
                    end
                end else if (s.awa == `CX_REG_COUNT) begin
                    next_s.count = 16'h0000;
                end else if (s.awa != `CX_REG_STATUS) begin
                    next_s.br = 2'h3;
                end
            end
            if (s.bv && bready) begin
                next_s.bv = 1'h0;
            end
            if (s.rv && rready) begin
                next_s.rv = 1'h0;
            end
            if (arvalid && arready) begin
                next_s.rv = 1'h1;
                next_s.rr = 2'h0;
                case (araddr)
                    `CX_REG_CTRL: next_s.rd = {31'h0, s.en};
                    `CX_REG_STATUS: next_s.rd = {14'h0, s.tpend, s.cof,
                        s.last_vec, 2'h0, s.st};
                    `CX_REG_COUNT: next_s.rd = {16'h0, s.count};
                    default: begin
                        next_s.rd = 32'h0;
                        next_s.rr = 2'h3;
                    end
                endcase
            end

            case (s.st)
                S_IDLE: begin
                    if (ev.start && s.en) begin
                        next_s.op = ev.op;
                        next_s.tmode = ev.tmode;
                        // save, restore and conditional keep their
                        // dialogue; only general reads on for trace each
                        next_s.tpend = (ev.op == OP_GEN) &&
                            (ev.tmode == `CX_TM_EACH);
                        next_s.cof = 1'h0;
                        next_s.first = 1'h1;
                        next_s.trc = 1'h0;
                        next_s.irqw = 1'h0;
                        next_s.st = S_DIALOG;
                    end
                end
                S_DIALOG: begin
                    next_s.cof = cof_now;
                    if (ev.bus_err) begin
                        ld = 1'h1;
                        if (s.first) begin
                            // no answer at all: no coprocessor there
                            ldq.vec = `CX_VEC_FLINE;
                            ldq.frm = FR_FOUR;
                        end else begin
                            ldq.vec = `CX_VEC_BUSERR;
                            ldq.frm = FR_TEN;
                        end
                        next_s.st = S_EXC;
                    end else if (ev.odd_fetch) begin
                        ld = 1'h1;
                        ldq.vec = `CX_VEC_ADDRERR;
                        ldq.frm = FR_TEN;
                        next_s.st = S_EXC;
                    end else if (ev.fmt_vld && ev.fmt_len[1:0] != 2'h0)
                    begin
                        if (s.op == OP_REST) begin
                            restore_wr = 1'h1;
                            next_s.st = S_REPLY;
                        end else begin
                            next_s.st = S_ABORT;
                        end
                    end else if (ev.fmt_notready && s.op == OP_SAVE)
                    begin
                        // four-word frame restarts the save on return
                        if (ev.irq_pend) begin
                            ld = 1'h1;
                            ldq.vec = ev.irq_vec;
                            ldq.frm = FR_FOUR;
                            next_s.irqw = 1'h1;
                            next_s.st = S_EXC;
                        end else begin
                            resp_read = 1'h1;
                        end
                    end else if (ev.prim_vld) begin
                        next_s.first = 1'h0;
                        if (s.op == OP_TRAP && p.is_null && p.tf &&
                                !p.ca) begin
                            ld = 1'h1;
                            ldq.vec = `CX_VEC_TRAP;
                            ldq.frm = FR_SIX;
                            next_s.fpc = ev.next_pc;
                            next_s.trc = take_trc;
                            next_s.st = S_EXC;
                        end else if (p.is_pre || p.is_mid || p.is_post)
                        begin
                            ld = 1'h1;
                            ldq.vec = p.vec;
                            ldq.frm = p.is_pre ? FR_FOUR :
                                (p.is_mid ? FR_TEN : FR_SIX);
                            next_s.trc = p.is_post && take_trc;
                            next_s.st = S_EXC;
                        end else if (p.is_null && p.ia && (p.ca ||
                                (s.tpend && !p.pf))) begin
                            if (ev.irq_pend) begin
                                ld = 1'h1;
                                ldq.vec = ev.irq_vec;
                                ldq.frm = FR_TEN;
                                next_s.irqw = 1'h1;
                                next_s.st = S_EXC;
                            end else begin
                                resp_read = 1'h1;
                            end
                        end else if (!p.ca && (!s.tpend ||
                                (p.is_null && p.pf))) begin
                            // coprocessor may keep running alone
                            dialog_end = 1'h1;
                            if (take_trc) begin
                                ld = 1'h1;
                                ldq.vec = `CX_VEC_TRACE;
                                ldq.frm = FR_SIX;
                                next_s.st = S_EXC;
                            end else begin
                                next_s.st = S_IDLE;
                            end
                        end else begin
                            // busy null answers keep the loop going
                            resp_read = 1'h1;
                        end
                    end else if (ev.done) begin
                        if (take_trc) begin
                            ld = 1'h1;
                            ldq.vec = `CX_VEC_TRACE;
                            ldq.frm = FR_SIX;
                            next_s.st = S_EXC;
                        end else begin
                            next_s.st = S_IDLE;
                        end
                    end
                end
                S_REPLY: begin
                    if (ev.reply_vld) begin
                        next_s.st = S_ABORT;
                    end
                end
                S_ABORT: begin
                    abort_wr = 1'h1;
                    ld = 1'h1;
                    ldq.vec = `CX_VEC_FMT;
                    ldq.frm = FR_FOUR;
                    next_s.st = S_EXC;
                end
                S_EXC: begin
                    if (req_valid && req_ready) begin
                        if (s.trc) begin
                            ld = 1'h1;
                            ldq.vec = `CX_VEC_TRACE;
                            ldq.frm = FR_SIX;
                            next_s.trc = 1'h0;
                        end else if (s.irqw) begin
                            next_s.st = S_IRQ;
                        end else begin
                            next_s.st = S_IDLE;
                        end
                    end
                end
                S_IRQ: begin
                    if (ev.exc_ret) begin
                        resp_read = 1'h1;
                        next_s.irqw = 1'h0;
                        next_s.st = S_DIALOG;
                    end
                end
                default: next_s.st = S_IDLE;
            endcase
            if (ld) begin
                next_s.last_vec = ldq.vec;
                next_s.count = s.count + 16'h0001;
            end
        end
    end

    // ==========================================================
    // only the external reset clears this block
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.st <= S_IDLE;
            s.en <= `CX_CTRL_EN_RST;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign bvalid = s.bv;
    assign bresp = s.br;
    assign rvalid = s.rv;
    assign rdata = s.rd;
    assign rresp = s.rr;
    assign frame_pc = s.fpc;

    // ==========================================================
    // checks, valid while ce stays high
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || !ce);

    sequence bad_save;
        s.st == S_DIALOG && s.op == OP_SAVE && ev.fmt_vld &&
            ev.fmt_len[1:0] != 2'h0 && !ev.bus_err && !ev.odd_fetch;
    endsequence
    sequence abort_then_fmt;
        abort_wr && ld && ldq.vec == 8'h0E && ldq.frm == FR_FOUR;
    endsequence

    a_trap_frame: assert property (ld && ldq.vec == 8'h07 &&
        s.op == OP_TRAP |-> ldq.frm == FR_SIX)
        else $error("trap not on six-word frame");
    a_trap_pc: assert property (s.op == OP_TRAP && ld && ldq.vec ==
        8'h07 && ce ##1 1 |-> frame_pc == $past(ev.next_pc))
        else $error("trap frame pc not next instruction");
    a_save_abort: assert property (bad_save ##1 ce |->
        abort_then_fmt)
        else $error("save format error without abort");
    a_fline_first: assert property (s.st == S_DIALOG && s.first &&
        ev.bus_err |-> ld && ldq.vec == 8'h0B &&
        ldq.frm == FR_FOUR)
        else $error("absent coprocessor not line emulator");
    a_early_end: assert property (s.st == S_DIALOG && !s.tpend &&
        ev.prim_vld && !p.ca && p.is_null && !ev.bus_err &&
        !ev.odd_fetch && !ev.fmt_vld && !ev.fmt_notready &&
        s.op == OP_GEN |-> dialog_end)
        else $error("dialogue not ended on come-again clear");
    a_trace_busy: assert property (s.st == S_DIALOG && s.tpend &&
        ev.prim_vld && p.is_null && !p.ca && !p.pf && !p.ia &&
        !ev.bus_err && !ev.odd_fetch && !ev.fmt_vld &&
        !ev.fmt_notready |-> resp_read && !dialog_end)
        else $error("trace pending dialogue ended early");
    a_irq_reread: assert property (s.st == S_IRQ && ev.exc_ret |->
        resp_read ##1 s.st == S_DIALOG)
        else $error("no reread after interrupt return");
    a_irq_ten: assert property (s.st == S_DIALOG && ev.prim_vld &&
        p.is_null && p.ca && p.ia && ev.irq_pend && !ev.bus_err &&
        !ev.odd_fetch && !ev.fmt_vld && !ev.fmt_notready |->
        ld && ldq.frm == FR_TEN)
        else $error("interrupt window not serviced on ten-word frame");
endmodule : coproc_exception_sequencer
`default_nettype wire

// ---- rtl/cx_map.svh ----
// constants of the coprocessor exception sequencer
// How it works
// - true trap: six-word frame, vector 7
// - trap frame pc is next instruction
// - trace every instruction, or on flow change
// - pending trace waits for instruction end
// - no trace: stop dialogue on come-again clear
// - trace pending: read until finished or post
// - flow mode general: trace on status direction
// - null, come-again, interrupts: service interrupts
// - trace pending null, not finished: interrupts
// - null-answer interrupts use ten-word frame, then reread
// - save not ready: four-word frame interrupts
// - length not multiple of four: format error
// - bad save length: abort, then format error
// - bad restore length: write, read, abort, error
// - format error: four-word frame, vector 14
// - first access bus error: absent coprocessor
// - later bus errors: resumable bus error
// - odd prefetch address: address error fault
// - line emulator: four-word frame, vector 11
`ifndef CX_MAP_SVH
`define CX_MAP_SVH
// ==========================================================
// register offsets and reset values
`define CX_REG_CTRL 4'h0
`define CX_REG_STATUS 4'h4
`define CX_REG_COUNT 4'h8
`define CX_CTRL_EN_RST 1'h1
// ==========================================================
// vectors
`define CX_VEC_TRAP 8'h07
`define CX_VEC_FMT 8'h0E
`define CX_VEC_FLINE 8'h0B
`define CX_VEC_BUSERR 8'h02
`define CX_VEC_ADDRERR 8'h03
`define CX_VEC_TRACE 8'h09
// ==========================================================
// trace modes and primitive fields
`define CX_TM_EACH 2'h2
`define CX_TM_FLOW 2'h1
`define CX_B_CA 15
`define CX_B_DR 13
`define CX_B_IA 8
`define CX_B_PF 1
`define CX_B_TF 0
`define CX_PR_NULL 5'h04
`define CX_PR_STAT 4'h1
`define CX_PR_PRE 6'h1C
`define CX_PR_MID 6'h1D
`define CX_PR_POST 6'h1E
`endif

// ---- rtl/cx_pkg.sv ----
// types shared by the coprocessor exception sequencer
package cx_pkg;
    typedef enum logic [2:0] {
        OP_GEN = 3'h0, OP_COND = 3'h1, OP_TRAP = 3'h2,
        OP_SAVE = 3'h3, OP_REST = 3'h4, OP_BR = 3'h5
    } op_e;
    typedef enum logic [1:0] {
        FR_FOUR = 2'h0, FR_SIX = 2'h1, FR_TEN = 2'h2
    } frame_e;
    typedef enum logic [5:0] {
        S_IDLE = 6'h01, S_DIALOG = 6'h02, S_IRQ = 6'h04,
        S_REPLY = 6'h08, S_ABORT = 6'h10, S_EXC = 6'h20
    } state_e;
    typedef struct packed {
        logic ca, dr, ia, pf, tf;
        logic is_null, is_stat, is_pre, is_mid, is_post;
        logic [7:0] vec;
    } prim_s;
    typedef struct packed {
        logic [7:0] vec;
        frame_e frm;
    } req_s;
    typedef struct packed {
        logic start;
        op_e op;
        logic [1:0] tmode;
        logic flow_chg;
        logic prim_vld;
        logic [15:0] prim;
        logic fmt_vld;
        logic [7:0] fmt_len;
        logic fmt_notready;
        logic reply_vld;
        logic done;
        logic bus_err;
        logic odd_fetch;
        logic irq_pend;
        logic [7:0] irq_vec;
        logic exc_ret;
        logic [31:0] next_pc;
    } ev_s;
endpackage : cx_pkg

// ---- rtl/exc_request.sv ----
// holding register for the single request to the exception unit
`timescale 1ns/1ps
`default_nettype none
module exc_request
    import cx_pkg::*;
(
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // load side
    input wire logic ld,
    input wire cx_pkg::req_s d,
    // exception unit side
    output logic valid,
    input wire logic ready,
    output cx_pkg::req_s q
);
    import cx_pkg::*;
    typedef struct packed {
        logic valid;
        req_s q;
    } rq_s;
    rq_s s;
    rq_s next_s;
    // ==========================================================
    // one request stands until taken; a follow-up trace loads as it goes
    always_comb begin
        next_s = s;
        if (s.valid && ready) begin
            next_s.valid = 1'h0;
        end
        if (ld && (!s.valid || ready)) begin
            next_s.valid = 1'h1;
            next_s.q = d;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end
    assign valid = s.valid;
    assign q = s.q;
    a_req_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && s.valid && !ready |=> s.valid && $stable(s.q))
        else $error("request dropped or changed before taken");
endmodule : exc_request
`default_nettype wire

// ---- rtl/prim_decode.sv ----
// field decoder for a coprocessor response primitive
`timescale 1ns/1ps
`default_nettype none
`include "cx_map.svh"
module prim_decode
    import cx_pkg::*;
(
    // primitive in, fields out
    input wire logic [15:0] word,
    output cx_pkg::prim_s p
);
    // ==========================================================
    // flags and kinds
    assign p.ca = word[`CX_B_CA];
    assign p.dr = word[`CX_B_DR];
    assign p.ia = word[`CX_B_IA];
    assign p.pf = word[`CX_B_PF];
    assign p.tf = word[`CX_B_TF];
    assign p.is_null = (word[13:9] == `CX_PR_NULL);
    assign p.is_stat = (word[12:9] == `CX_PR_STAT);
    // exception primitives carry come-again clear in bit 15
    assign p.is_pre = !word[15] && (word[13:8] == `CX_PR_PRE);
    assign p.is_mid = !word[15] && (word[13:8] == `CX_PR_MID);
    assign p.is_post = !word[15] && (word[13:8] == `CX_PR_POST);
    assign p.vec = word[7:0];
endmodule : prim_decode
`default_nettype wire

// ---- tb/coproc_exception_sequencer_tb.sv ----
// bench for the coprocessor exception sequencer
`timescale 1ns/1ps
`default_nettype none
`include "cx_map.svh"
module coproc_exception_sequencer_tb;
    import cx_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, req_ready = 0, m_vld, ce = 1;
    logic awready, wready, bvalid, arready, rvalid, req_valid;
    logic resp_read, abort_wr, restore_wr, dialog_end;
    logic [3:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, frame_pc, d;
    logic [1:0] bresp, rresp, r;
    logic [15:0] m_word;
    ev_s ev = '0, evc, b, e;
    req_s req;
    int num_errors = 0, samples_checked = 0, reads = 0, aborts = 0;
    int rests = 0, ends = 0, reqs = 0;
    always #25 aclk = ~aclk;
    // model answers override the primitive fields
    always_comb begin
        evc = ev;
        if (m_vld) begin
            evc.prim_vld = 1'b1;
            evc.prim = m_word;
        end
    end
    always @(posedge aclk) begin
        reads <= reads + resp_read;
        aborts <= aborts + abort_wr;
        rests <= rests + restore_wr;
        ends <= ends + dialog_end;
    end
    coproc_exception_sequencer u_dut (.aclk(aclk), .aresetn(aresetn),
        .ce(ce), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp), .ev(evc),
        .resp_read(resp_read), .abort_wr(abort_wr),
        .restore_wr(restore_wr), .dialog_end(dialog_end),
        .req_valid(req_valid), .req_ready(req_ready), .req(req),
        .frame_pc(frame_pc));
    coproc_model u_cp (.aclk(aclk), .aresetn(aresetn),
        .resp_read(resp_read), .busy_n(4'h2), .vld(m_vld), .word(m_word));
    // ==========================================================
    // helpers
    task chk(input string n, input logic [31:0] s, input logic [31:0] x);
        samples_checked++;
        if (s !== x) begin
            num_errors++;
            $display("BAD %s exp %h got %h", n, x, s);
        end
    endtask : chk
    task tally_and_finish;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    task rd(input logic [3:0] a);
        // an edge first, so rready is never dropped and raised in one step
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge aclk); while (!arready);
        @(posedge aclk) arvalid <= 1'b0;
        do @(negedge aclk); while (!rvalid);
        d = rdata;
        r = rresp;
        @(posedge aclk) rready <= 1'b0;
    endtask : rd
    task wr(input logic [3:0] a, input logic [31:0] x);
        logic ta, tw;
        awaddr <= a;
        wdata <= x;
        {awvalid, wvalid, bready} <= 3'b111;
        // aw and w may be taken at different edges
        do begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while ((awvalid && !ta) || (wvalid && !tw));
        do @(negedge aclk); while (!bvalid);
        @(posedge aclk) bready <= 1'b0;
    endtask : wr
    task pulse;
        @(posedge aclk) ev <= e;
        @(posedge aclk) ev <= b;
    endtask : pulse
    task go(input op_e o, input logic [1:0] t);
        repeat (4) @(posedge aclk);
        b = '0;
        b.op = o;
        b.tmode = t;
        b.next_pc = 32'h0000_1236;
        e = b;
        e.start = 1'b1;
        pulse();
    endtask : go
    task pr(input logic [15:0] w);
        e = b;
        e.prim_vld = 1'b1;
        e.prim = w;
        pulse();
    endtask : pr
    task take(input logic [7:0] v, input frame_e f);
        do @(negedge aclk); while (req_valid !== 1'b1);
        chk("vec", req.vec, v);
        chk("frm", req.frm, f);
        reqs++;
        @(posedge aclk) req_ready <= 1'b1;
        @(posedge aclk) req_ready <= 1'b0;
    endtask : take
    function automatic logic [15:0] nul(logic ca, ia, pf, tf);
        return {ca, 4'h1, 2'b00, ia, 6'h00, pf, tf};
    endfunction : nul
    // ==========================================================
    // tests
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`CX_REG_CTRL);
        chk("ctrl", d, 32'h1);
        rd(4'hC);
        chk("decerr", r, 2'h3);
        go(OP_TRAP, 2'h0);
        pr(nul(0, 0, 0, 1));
        take(`CX_VEC_TRAP, FR_SIX);
        chk("pc", frame_pc, 32'h0000_1236);
        go(OP_GEN, `CX_TM_EACH);
        pr(nul(0, 0, 0, 0));
        take(`CX_VEC_TRACE, FR_SIX);
        chk("reads", reads, 3);
        go(OP_GEN, 2'h0);
        pr(nul(0, 0, 0, 0));
        go(OP_GEN, 2'h0);
        chk("noreq", req_valid, 1'b0);
        chk("reads", reads, 3);
        chk("ends", ends, 2);
        b.irq_pend = 1'b1;
        b.irq_vec = 8'h40;
        pr(nul(1, 1, 0, 0));
        take(8'h40, FR_TEN);
        b.irq_pend = 1'b0;
        e = b;
        e.exc_ret = 1'b1;
        pulse();
        repeat (2) @(posedge aclk);
        chk("reread", reads, 4);
        go(OP_SAVE, 2'h0);
        b.irq_pend = 1'b1;
        b.irq_vec = 8'h40;
        e = b;
        e.fmt_notready = 1'b1;
        pulse();
        take(8'h40, FR_FOUR);
        b.irq_pend = 1'b0;
        e = b;
        e.exc_ret = 1'b1;
        pulse();
        repeat (2) @(posedge aclk);
        chk("restart", reads, 5);
        go(OP_SAVE, 2'h0);
        e = b;
        e.fmt_vld = 1'b1;
        e.fmt_len = 8'h06;
        pulse();
        take(`CX_VEC_FMT, FR_FOUR);
        chk("abort", aborts, 1);
        go(OP_REST, 2'h0);
        e = b;
        e.fmt_vld = 1'b1;
        e.fmt_len = 8'h0A;
        pulse();
        @(negedge aclk);
        chk("rest", rests, 1);
        chk("abort", aborts, 1);
        e = b;
        e.reply_vld = 1'b1;
        pulse();
        take(`CX_VEC_FMT, FR_FOUR);
        chk("abort", aborts, 2);
        go(OP_GEN, 2'h0);
        e = b;
        e.bus_err = 1'b1;
        pulse();
        take(`CX_VEC_FLINE, FR_FOUR);
        go(OP_GEN, 2'h0);
        // the fault lands on the model's answer, a later access
        e = b;
        e.prim_vld = 1'b1;
        e.prim = nul(1, 0, 0, 0);
        @(posedge aclk) ev <= e;
        e = b;
        e.bus_err = 1'b1;
        pulse();
        take(`CX_VEC_BUSERR, FR_TEN);
        go(OP_BR, 2'h0);
        e = b;
        e.odd_fetch = 1'b1;
        pulse();
        take(`CX_VEC_ADDRERR, FR_TEN);
        go(OP_GEN, `CX_TM_FLOW);
        pr({1'b0, 1'b0, 1'b1, 4'h1, 9'h000});
        take(`CX_VEC_TRACE, FR_SIX);
        // a start offered while frozen must leave the sequencer idle
        ce <= 1'b0;
        go(OP_GEN, 2'h0);
        ce <= 1'b1;
        rd(`CX_REG_STATUS);
        chk("frozen", d[5:0], 6'h01);
        rd(`CX_REG_COUNT);
        chk("count", d[15:0], reqs);
        wr(`CX_REG_COUNT, 32'h0);
        rd(`CX_REG_COUNT);
        chk("clear", d[15:0], 16'h0000);
        tally_and_finish();
    end
    // watchdog cuts a hang well past the expected run
    initial begin
        repeat (5000) @(posedge aclk);
        num_errors++;
        tally_and_finish();
    end
endmodule : coproc_exception_sequencer_tb
`default_nettype wire

// ---- tb/coproc_model.sv ----
// coprocessor model answering response register reads
`timescale 1ns/1ps
`default_nettype none
module coproc_model (
    // clock and external reset
    input wire logic aclk,
    input wire logic aresetn,
    // register side
    input wire logic resp_read,
    input wire logic [3:0] busy_n,
    output logic vld,
    output logic [15:0] word
);
    logic [3:0] left;
    // only the external reset clears the model
    always @(posedge aclk) begin
        if (!aresetn) begin
            left <= busy_n;
            vld <= 1'b0;
            word <= 16'h0000;
        end else if (resp_read) begin
            vld <= 1'b1;
            // null, come-again clear, finished once busy runs out
            word <= {8'h08, 6'h00, (left == 4'h0), 1'b0};
            left <= (left == 4'h0) ? busy_n : left - 4'h1;
        end else begin
            vld <= 1'b0;
            word <= ~word; // no stale value between answers
        end
    end
endmodule : coproc_model
`default_nettype wire
